// ==== rtl/uvdm_defines.vh ====
`ifndef UVDM_DEFINES_VH
`define UVDM_DEFINES_VH

// Register indices; byte address is four times the index
`define UVDM_IDX_UV_FLAGS 8'h27
`define UVDM_IDX_MUX_12 8'h28
`define UVDM_IDX_MUX_34 8'h29
`define UVDM_IDX_MUX_56 8'h2A
`define UVDM_IDX_MUX_78 8'h2B
`define UVDM_IDX_CHECK_EN 8'h40
`define UVDM_IDX_IRQ_STATUS 8'h41
`define UVDM_IDX_IRQ_MASK 8'h42

// Reset values
`define UVDM_RST_UV_FLAGS 8'h00
`define UVDM_RST_MUX 6'h00
`define UVDM_RST_CHECK_EN 8'h00
`define UVDM_RST_IRQ_MASK 8'h00

// Field positions in a multiplexer register
`define UVDM_MUX_LO_LSB 0
`define UVDM_MUX_HI_LSB 3
`define UVDM_MUX_FIELD_W 3

// Monitor source encodings
`define UVDM_SRC_PIN 3'h0
`define UVDM_SRC_TEMP 3'h1
`define UVDM_SRC_REF_X4 3'h2
`define UVDM_SRC_ANALOG_CORE_REGULATOR_X4 3'h3
`define UVDM_SRC_CORE_X4 3'h4
`define UVDM_SRC_IFACE 3'h5
`define UVDM_SRC_GND 3'h6
`define UVDM_SRC_SUPPLY 3'h7

// One-hot route codes driven to the analog switch
`define UVDM_RT_PIN 8'h01
`define UVDM_RT_TEMP 8'h02
`define UVDM_RT_REF_X4 8'h04
`define UVDM_RT_ANALOG_CORE_REGULATOR_X4 8'h08
`define UVDM_RT_DIGITAL_CORE_REGULATOR_X4 8'h10
`define UVDM_RT_IFACE 8'h20
`define UVDM_RT_GND 8'h40
`define UVDM_RT_SUPPLY 8'h80

`endif

// ==== rtl/uvdm_regs.v ====
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
module uvdm_regs (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  input wire clk_en,
  // Avalon-MM slave
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Comparator outputs, one per channel, level
  input wire [7:0] low_voltage_detect,
  // Per-channel one-hot source routes
  output reg [63:0] monitor_route,
  // Channels that need the 10 V range
  output reg [7:0] wide_range_needed,
  // Interrupt
  output reg irq
);
`include "uvdm_defines.vh"

  reg [7:0] uv_flags_q;
  reg [7:0] uv_flags_d;
  reg [7:0] check_en_q;
  reg [7:0] irq_status_q;
  reg [7:0] irq_status_d;
  reg [7:0] irq_mask_q;
  reg [5:0] mux_q [0:3];
  reg ack_q;
  reg [31:0] rdata_d;
  wire [7:0] idx;
  wire acc;
  wire wr;
  wire [7:0] wbyte;
  wire [7:0] new_uv;
  wire [63:0] route_w;
  wire [23:0] sel_flat;
  integer i;
  integer k;

  // Word index from byte address
  assign idx = avs_address[9:2];
  assign acc = (avs_read | avs_write) & ~ack_q;
  // A write lands at the edge where the master sees waitrequest low
  assign wr = avs_write & ack_q & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  function is_mux;
    input [7:0] a;
    begin
      is_mux = (a == `UVDM_IDX_MUX_12) || (a == `UVDM_IDX_MUX_34) ||
        (a == `UVDM_IDX_MUX_56) || (a == `UVDM_IDX_MUX_78);
    end
  endfunction

  function [1:0] mux_slot;
    input [7:0] a;
    begin
      // Select registers start on an index whose low two bits are zero
      mux_slot = a[1:0];
    end
  endfunction

  // Detections seen this cycle on enabled channels whose flag is not already set
  assign new_uv = low_voltage_detect & check_en_q & ~uv_flags_q;

  always @*
  begin
    uv_flags_d = uv_flags_q;
    if (wr && idx == `UVDM_IDX_UV_FLAGS)
      uv_flags_d = uv_flags_q & ~wbyte;
    // A new detection wins over a clear in the same cycle
    uv_flags_d = uv_flags_d | (low_voltage_detect & check_en_q);
    irq_status_d = irq_status_q;
    if (wr && idx == `UVDM_IDX_IRQ_STATUS)
      irq_status_d = irq_status_q & ~wbyte;
    irq_status_d = irq_status_d | new_uv;
  end

  always @*
  begin
    rdata_d = 32'h00000000;
    if (is_mux(idx))
      rdata_d = {26'h0000000, mux_q[mux_slot(idx)]};
    else
      case (idx)
        `UVDM_IDX_UV_FLAGS: rdata_d = {24'h000000, uv_flags_q};
        `UVDM_IDX_CHECK_EN: rdata_d = {24'h000000, check_en_q};
        `UVDM_IDX_IRQ_STATUS: rdata_d = {24'h000000, irq_status_q};
        `UVDM_IDX_IRQ_MASK: rdata_d = {24'h000000, irq_mask_q};
        default: rdata_d = 32'h00000000;
      endcase
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      uv_flags_q <= `UVDM_RST_UV_FLAGS;
      check_en_q <= `UVDM_RST_CHECK_EN;
      irq_status_q <= 8'h00;
      irq_mask_q <= `UVDM_RST_IRQ_MASK;
      for (i = 0; i < 4; i = i + 1)
        mux_q[i] <= `UVDM_RST_MUX;
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      uv_flags_q <= uv_flags_d;
      irq_status_q <= irq_status_d;
      ack_q <= acc;
      avs_waitrequest <= ~acc;
      if (acc && avs_read)
        avs_readdata <= rdata_d;
      if (wr && is_mux(idx))
        // Fields 5:0 stored, bits 7:6 dropped
        mux_q[mux_slot(idx)] <= wbyte[5:0];
      if (wr && idx == `UVDM_IDX_CHECK_EN)
        check_en_q <= wbyte;
      if (wr && idx == `UVDM_IDX_IRQ_MASK)
        irq_mask_q <= wbyte;
      irq <= |(irq_status_d & irq_mask_q);
    end
  end

  // Flatten selects: channel 2k+1 low field, channel 2k+2 high field
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_pair
      assign sel_flat[6*g +: 3] = mux_q[g][`UVDM_MUX_LO_LSB +: 3];
      assign sel_flat[6*g+3 +: 3] = mux_q[g][`UVDM_MUX_HI_LSB +: 3];
    end
    for (g = 0; g < 8; g = g + 1)
    begin : g_chan
      uvdm_route_decode #(
        .ODD_CHANNEL((g % 2) == 0)
      ) u_dec (
        .sel(sel_flat[3*g +: 3]),
        .route(route_w[8*g +: 8])
      );
    end
  endgenerate

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      monitor_route <= {8{`UVDM_RT_PIN}};
      wide_range_needed <= 8'h00;
    end
    else if (clk_en)
    begin
      monitor_route <= route_w;
      for (k = 0; k < 8; k = k + 1)
        // Flag for the host, which owns the range setting
        wide_range_needed[k] <= (sel_flat[3*k +: 3] != `UVDM_SRC_PIN);
    end
  end

endmodule

// ==== rtl/uvdm_route_decode.v ====
`timescale 1ns/1ps
// Turns one 3-bit source select into a one-hot switch control
module uvdm_route_decode #(
  parameter ODD_CHANNEL = 1
) (
  // Select in
  input wire [2:0] sel,
  // One-hot route out
  output reg [7:0] route
);
`include "uvdm_defines.vh"

  always @*
  begin
    case (sel)
      `UVDM_SRC_PIN: route = `UVDM_RT_PIN;
      `UVDM_SRC_TEMP: route = `UVDM_RT_TEMP;
      `UVDM_SRC_REF_X4: route = `UVDM_RT_REF_X4;
      `UVDM_SRC_ANALOG_CORE_REGULATOR_X4: route = `UVDM_RT_ANALOG_CORE_REGULATOR_X4;
      `UVDM_SRC_CORE_X4: route = (ODD_CHANNEL != 0) ?
        `UVDM_RT_DIGITAL_CORE_REGULATOR_X4 : `UVDM_RT_ANALOG_CORE_REGULATOR_X4;
      `UVDM_SRC_IFACE: route = `UVDM_RT_IFACE;
      `UVDM_SRC_GND: route = `UVDM_RT_GND;
      `UVDM_SRC_SUPPLY: route = `UVDM_RT_SUPPLY;
      default: route = `UVDM_RT_PIN;
    endcase
  end

endmodule

// ==== tb/uvdm_host.sv ====
`timescale 1ns/1ps
module uvdm_host (
  // Clock
  input wire sys_clk,
  // Avalon-MM master
  output logic [9:0] avs_address = 10'h000,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [31:0] avs_writedata = 32'h0,
  output logic [3:0] avs_byteenable = 4'hF,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest
);
  // Holds the request until an edge samples the acknowledge
  task automatic xfer(input logic w, input logic [9:0] a,
    input logic [7:0] d, output logic [7:0] q);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    @(posedge sys_clk);
    while (avs_waitrequest)
      @(posedge sys_clk);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule

// ==== tb/uvdm_regs_props.sv ====
`timescale 1ns/1ps
module uvdm_regs_props (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Bus
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Routes
  input wire [63:0] monitor_route,
  input wire [7:0] wide_range_needed
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack too long");
  a_ack_due: assert property ($rose(avs_read | avs_write) |->
    ##[1:2] !avs_waitrequest) else $error("no ack");
  a_read_upper: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:8] == 24'h0) else $error("upper bits");
  a_mux_reserved: assert property (avs_read && !avs_waitrequest &&
    avs_address[9:4] == 6'h0A |-> avs_readdata[7:6] == 2'h0) else $error("rsv");
  a_pin_default: assert property (!wide_range_needed[0] |->
    monitor_route[7:0] == 8'h01) else $error("pin route");
  a_wide_tracks: assert property (wide_range_needed[1] == !monitor_route[8])
    else $error("wide flag");
  a_route_onehot: assert property ($onehot(monitor_route[23:16]))
    else $error("onehot");
  a_even_no_core: assert property (monitor_route[28] == 1'b0)
    else $error("even core");
  c_core: cover property (monitor_route[4]);
  c_write: cover property (avs_write && !avs_waitrequest);
  c_wide: cover property (&wide_range_needed);
endmodule
bind uvdm_regs uvdm_regs_props props (
  .sys_clk(sys_clk),
  .reset(reset),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .monitor_route(monitor_route),
  .wide_range_needed(wide_range_needed)
);

// ==== tb/uvdm_regs_test.sv ====
`timescale 1ns/1ps
module uvdm_regs_test;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] low_voltage_detect = 8'h00;
  wire [9:0] avs_address;
  wire avs_read, avs_write, avs_waitrequest, irq;
  wire [31:0] avs_writedata, avs_readdata;
  wire [3:0] avs_byteenable;
  wire [63:0] monitor_route;
  wire [7:0] wide_range_needed;
  int n_errors = 0;
  int comparisons = 0;
  logic [7:0] q;
  // Row index is the select; even channel byte above odd
  logic [15:0] rt [8] = '{16'h0101, 16'h0202, 16'h0404, 16'h0808,
    16'h0810, 16'h2020, 16'h4040, 16'h8080};
  initial forever #12.5 sys_clk = ~sys_clk;
  uvdm_host host (.*);
  uvdm_regs uut (.*);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task rd(input logic [9:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task report_and_stop;
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(10'h09C, 8'h00);
    rd(10'h0A0, 8'h00);
    chk(monitor_route[7:0], 8'h01);
    for (int s = 0; s < 8; s++)
      for (int j = 0; j < 4; j++)
      begin
        wr(10'h0A0 + 10'(4 * j), {2'b11, 3'(s), 3'(s)});
        rd(10'h0A0 + 10'(4 * j), {2'b00, 3'(s), 3'(s)});
        chk(monitor_route[16*j+:16], rt[s]);
      end
    chk(wide_range_needed, 8'hFF);
    rd(10'h3FC, 8'h00);
    wr(10'h100, 8'h0F);
    low_voltage_detect <= 8'hFF;
    repeat (2) @(posedge sys_clk);
    low_voltage_detect <= 8'h00;
    rd(10'h09C, 8'h0F);
    chk(irq, 1'b0);
    wr(10'h108, 8'hFF);
    rd(10'h104, 8'h0F);
    chk(irq, 1'b1);
    wr(10'h09C, 8'h05);
    rd(10'h09C, 8'h0A);
    wr(10'h104, 8'h0F);
    rd(10'h09C, 8'h0A);
    chk(irq, 1'b0);
    // Reset in mid-run brings every register back to its default
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(10'h09C, 8'h00);
    rd(10'h0AC, 8'h00);
    chk(monitor_route, {8{8'h01}});
    chk(wide_range_needed, 8'h00);
    chk(irq, 1'b0);
    // Write with byte lane 0 off is ignored
    host.avs_byteenable <= 4'h0;
    wr(10'h0A4, 8'h3F);
    host.avs_byteenable <= 4'hF;
    rd(10'h0A4, 8'h00);
    // Clock enable low freezes detection
    wr(10'h100, 8'h01);
    clk_en <= 1'b0;
    low_voltage_detect <= 8'h01;
    repeat (3) @(posedge sys_clk);
    low_voltage_detect <= 8'h00;
    @(posedge sys_clk);
    clk_en <= 1'b1;
    @(posedge sys_clk);
    rd(10'h09C, 8'h00);
    report_and_stop();
  end
endmodule
